// File: sram_pkg.sv
// Shared constants and types for the burst static memory control block.
package sram_pkg;
  localparam int ADDR_W       = 19;
  localparam int LANE_W       = 9;
  localparam int LANES        = 2;
  localparam int WORD_W       = LANE_W * LANES;
  localparam int BURST_W      = 2;
  localparam int FIFO_DEPTH   = 16;
  localparam logic [1:0] BURST_START = 2'h0;
  localparam logic [1:0] BURST_ONE   = 2'h1;
  localparam logic [2:0] SYNC_RESET  = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } cycle_t;
endpackage

// File: word_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } fifo_state_t;

  fifo_state_t          state;
  fifo_state_t          next_state;
  logic [WIDTH-1:0]     mem [DEPTH];
  logic                 push;
  logic                 pop;

  assign o_in_ready  = (state.count != (AW+1)'(DEPTH));
  assign o_out_valid = (state.count != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[state.rd];

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr = state.wr + 1'b1;
    end
    if (pop) begin
      next_state.rd = state.rd + 1'b1;
    end
    next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Storage has no reset so it can map onto plain memory.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[state.wr] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// File: sync_burst_sram_control.sv
// Control, write decoding and data path of a pipelined burst static memory.
//
// How it works
// R01 - Global write strobe low writes all lanes.
// R02 - Lane strobes count only with byte gate low.
// R03 - Write exactly the lanes whose strobes are low.
// R04 - Any lane strobe active means write, else read.
// R05 - Synchronous inputs sampled on rising clock edge.
// R06 - Address captured when selected and strobe asserted.
// R07 - Drive data only when enabled and output enabled.
// R08 - Master select blocks processor strobe when inactive.
// R09 - Secondary selects sampled on qualifying strobe edges.
// R10 - Processor strobe loads address or enters standby.
// R11 - Controller strobe loads address or enters standby.
// R12 - Burst step low advances to next burst address.
// R13 - Output enable asynchronous; drive only in reads.
// R14 - Count order: high interleaved, low linear.
// R15 - Bypass select low removes output register stage.
// R16 - Sleep input forces low power, keeps contents.
// R17 - Pipelined read data appears after next edge.
// R18 - Step ignored on processor strobe edge.
// R19 - Lane strobes capture data, disable outputs.
// R20 - Controller cycle needs processor strobe high.
// R21 - Flow-through read data appears same cycle.
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_control
  import sram_pkg::*;
#(
  parameter int AW    = ADDR_W,
  parameter int LW    = LANE_W,
  parameter int NL    = LANES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [AW-1:0]    i_word_address,
  input  wire logic             i_master_select_n,
  input  wire logic             i_secondary_select_hi,
  input  wire logic             i_secondary_select_lo_n,
  input  wire logic             i_cpu_addr_strobe_n,
  input  wire logic             i_ctrl_addr_strobe_n,
  input  wire logic             i_burst_step_n,
  input  wire logic             i_global_write_n,
  input  wire logic             i_byte_write_gate_n,
  input  wire logic [NL-1:0]    i_lane_write_n,
  input  wire logic             i_output_enable_n,
  input  wire logic             i_count_order_sel,
  input  wire logic             i_bypass_pipe_n,
  input  wire logic             i_sleep_req,
  input  wire logic [NL*LW-1:0] i_data,
  output logic      [NL*LW-1:0] o_data,
  output logic      [NL*LW-1:0] o_data_oe_n,
  output logic                  o_sleeping,
  output logic                  o_selected,
  output logic      [AW-1:0]    o_cur_address,
  output logic      [NL-1:0]    o_lane_we,
  output logic                  o_wr_valid,
  input  wire logic             i_wr_ready,
  output logic      [AW-1:0]    o_wr_address,
  output logic      [NL-1:0]    o_wr_lanes,
  output logic      [NL*LW-1:0] o_wr_data,
  output logic      [AW-1:0]    o_rd_address,
  input  wire logic [NL*LW-1:0] i_rd_data
);
  localparam int WW = NL * LW;
  localparam int FW = AW + NL + WW;

  typedef struct packed {
    logic [2:0]    sleep_sync;
    logic          sleeping;
    cycle_t        cycle;
    logic [AW-1:0] base;
    logic [1:0]    offset;
    logic          read_live;
    logic          read_pipe;
    logic [WW-1:0] out_reg;
    logic [NL-1:0] lane_we;
  } ctrl_state_t;

  ctrl_state_t   state;
  ctrl_state_t   next_state;
  logic          cpu_start;
  logic          ctrl_start;
  logic          all_sel;
  logic          load;
  logic          deselect;
  logic [NL-1:0] lanes;
  logic          is_write;
  logic          step;
  logic [1:0]    burst_bits;
  logic [AW-1:0] cur_addr;
  logic          drive;

  // Overview of the timing at the pins.
  //
  // A cycle starts on an edge where one address strobe is low and the
  // three chip selects all read active. The address is registered on that
  // edge and becomes the burst base; the two low address bits are then
  // formed from the base and a two-bit burst offset that starts at zero.
  //
  // A processor strobe start is always a read, because the write strobes
  // are not looked at on that edge. A controller strobe start samples the
  // write strobes on its own edge, so it may open a write at once.
  //
  // On later edges, with both strobes high, the write strobes decide
  // again for each edge whether that edge writes or reads, and a low
  // burst step moves the offset on by one. A controller strobe edge with a
  // select inactive, or a processor strobe edge with the master select active
  // and a secondary select inactive, deselects the block and ends the burst.
  //
  // Read path. In pipelined mode the array word for the current address
  // is taken into the output register on the edge after the address was
  // registered, so the word reaches the pins one edge later than the
  // address. In flow-through mode the array word passes straight to the
  // pins, which saves that edge at the cost of a longer path from the
  // array to the pins; the user must allow for that in the clock period.
  //
  // Write path. A write edge produces a one-cycle lane pulse on the next
  // cycle. The data pins are sampled during that pulse, together with the
  // current burst address, and the three travel on into the write queue.
  // The queue lets the array side stall for a while without holding up
  // the bus. A write that meets a full queue is lost, so the master must
  // not run more than the queue depth of writes ahead of the array.
  //
  // Pin drive. The pins are driven only while output enable is low, the
  // block is awake, no lane pulse is active and a read is in the stage
  // that feeds the pins. Output enable acts without a clock, so a master
  // can release the bus at once before it turns the bus round for a
  // write.
  //
  // Sleep. The sleep request arrives from outside the clock domain and
  // passes three flops; it counts once the last two agree. While asleep
  // the block stays idle, makes no lane pulses and releases the pins. The
  // stored words are held, because the array itself is outside this
  // block and sees only the writes queued before sleep.
  //
  // Burst order. The count order select is static. High gives the
  // exclusive-or order, where the offset is flipped into the low address
  // bits; low gives the linear order, where the offset is added and the
  // sum wraps within the four-word group. The upper address bits never
  // change during a burst in either order.
  //
  // Reset. The pins have no reset of their own in the original part; the
  // reset input here only brings the registers to a known idle state so
  // that the first strobe after it is handled like any later one.

  assign all_sel = !i_master_select_n && i_secondary_select_hi
                   && !i_secondary_select_lo_n;
  // Master select gates only the processor strobe. [R08] [R09]
  assign cpu_start  = !i_cpu_addr_strobe_n && !i_master_select_n;
  // A controller cycle starts only with the processor strobe high. [R20]
  assign ctrl_start = !i_ctrl_addr_strobe_n && i_cpu_addr_strobe_n;
  assign load       = (cpu_start || ctrl_start) && all_sel; // [R06] [R10] [R11]
  assign deselect   = (cpu_start || ctrl_start) && !all_sel; // [R10] [R11]

  // Per-lane write decode; lane strobes ignored on processor edges. [R19]
  always_comb begin
    if (!i_global_write_n) begin
      lanes = '1; // [R01]
    end else if (!i_byte_write_gate_n) begin
      lanes = ~i_lane_write_n; // [R02] [R03]
    end else begin
      lanes = '0; // [R02]
    end
    if (cpu_start) begin
      lanes = '0;
    end
  end
  assign is_write = (lanes != '0); // [R04]

  // Step only with both strobes high; blocked on processor edge. [R12] [R18]
  assign step = !i_burst_step_n && i_cpu_addr_strobe_n
                && i_ctrl_addr_strobe_n && (state.cycle != ST_IDLE);

  // Interleaved order flips the low bits, linear order adds. [R14]
  assign burst_bits = i_count_order_sel
                      ? (state.base[1:0] ^ state.offset)
                      : (state.base[1:0] + state.offset);
  assign cur_addr   = {state.base[AW-1:2], burst_bits};

  always_comb begin
    next_state = state;
    // Sleep is asynchronous, so it passes three flops first. [R16]
    next_state.sleep_sync = {state.sleep_sync[1:0], i_sleep_req};
    if (state.sleep_sync[2] == state.sleep_sync[1]) begin
      next_state.sleeping = state.sleep_sync[2];
    end
    next_state.lane_we   = '0;
    next_state.read_live = 1'b0;
    if (state.sleeping) begin
      next_state.cycle = ST_IDLE;
    end else if (load) begin // [R05]
      next_state.base   = i_word_address;
      next_state.offset = BURST_START;
      next_state.cycle  = (ctrl_start && is_write) ? ST_WRITE : ST_READ;
      next_state.read_live = !(ctrl_start && is_write);
    end else if (deselect) begin
      next_state.cycle = ST_IDLE;
    end else if (state.cycle != ST_IDLE) begin
      if (step) begin
        next_state.offset = state.offset + BURST_ONE; // [R12]
      end
      next_state.cycle     = is_write ? ST_WRITE : ST_READ;
      next_state.read_live = !is_write;
    end
    // Neither the sleeping edge nor the waking edge may write.
    if (!state.sleeping && !next_state.sleeping
        && (load ? ctrl_start : state.cycle != ST_IDLE)) begin
      next_state.lane_we = lanes; // [R19]
    end
    // Output register holds data one edge later in pipelined mode. [R17]
    next_state.read_pipe = state.read_live;
    next_state.out_reg   = i_rd_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '{sleep_sync: SYNC_RESET,
                 sleeping:   1'b0,
                 cycle:      ST_IDLE,
                 base:       '0,
                 offset:     BURST_START,
                 read_live:  1'b0,
                 read_pipe:  1'b0,
                 out_reg:    '0,
                 lane_we:    '0};
    end else begin
      state <= next_state;
    end
  end

  // Write words queue here; a word that meets a full queue is lost.
  word_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (state.lane_we != '0),
    .o_in_ready  (),
    .i_in_data   ({cur_addr, state.lane_we, i_data}),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  ({o_wr_address, o_wr_lanes, o_wr_data})
  );

  assign o_rd_address = cur_addr;
  // Flow-through takes the array word straight through. [R15] [R21]
  assign o_data = i_bypass_pipe_n ? state.out_reg : i_rd_data;
  // Output enable is combinational; writes and sleep force release.
  assign drive = !i_output_enable_n && !state.sleeping
                 && (state.lane_we == '0)
                 && (i_bypass_pipe_n ? state.read_pipe : state.read_live);
  assign o_data_oe_n   = {WW{!drive}}; // [R07] [R13] [R19]
  assign o_sleeping    = state.sleeping;
  assign o_selected    = (state.cycle != ST_IDLE);
  assign o_cur_address = cur_addr;
  assign o_lane_we     = state.lane_we;
endmodule
`default_nettype wire

// File: sram_ctl_assertions.sv
// Port-level checks of the burst static memory control block.
`timescale 1ns/10ps
`default_nettype none
module sram_ctl_assertions (
  input wire logic        i_clk, i_rst_n, i_master_select_n,
  input wire logic        i_secondary_select_hi, i_secondary_select_lo_n,
  input wire logic        i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n,
  input wire logic        i_burst_step_n, i_global_write_n,
  input wire logic        i_byte_write_gate_n, i_output_enable_n,
  input wire logic        i_sleep_req, o_sleeping, o_selected,
  input wire logic [1:0]  i_lane_write_n, o_lane_we,
  input wire logic [18:0] i_word_address, o_cur_address,
  input wire logic [17:0] o_data_oe_n
);
  logic sel_ok, awake, cpu_go, ctl_go;
  assign sel_ok = !i_master_select_n && i_secondary_select_hi &&
                  !i_secondary_select_lo_n;
  // Sleep is synchronised inside, so both ends of it are excluded.
  assign awake  = !i_sleep_req && !o_sleeping;
  assign cpu_go = sel_ok && !i_cpu_addr_strobe_n && awake;
  assign ctl_go = sel_ok && i_cpu_addr_strobe_n && !i_ctrl_addr_strobe_n &&
                  awake;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_step;
    i_cpu_addr_strobe_n && i_ctrl_addr_strobe_n && !i_burst_step_n &&
    o_selected && awake;
  endsequence
  sequence s_blocked;
    !i_cpu_addr_strobe_n && i_master_select_n && i_ctrl_addr_strobe_n &&
    i_burst_step_n;
  endsequence
  a_global_all: assert property (ctl_go && !i_global_write_n |=>
    o_lane_we == 2'h3) else $error("global write missed a lane");
  a_gate_off: assert property (ctl_go && i_global_write_n &&
    i_byte_write_gate_n |=> o_lane_we == 2'h0) else $error("gated write");
  a_lane_pick: assert property (ctl_go && i_global_write_n &&
    !i_byte_write_gate_n |=> o_lane_we == ~$past(i_lane_write_n))
    else $error("wrong lanes written");
  a_cpu_no_write: assert property (cpu_go |=> o_lane_we == 2'h0)
    else $error("write on processor strobe edge");
  a_addr_load: assert property (cpu_go || ctl_go |=>
    o_cur_address == $past(i_word_address)) else $error("address not loaded");
  a_master_block: assert property (s_blocked |=> $stable(o_cur_address))
    else $error("blocked start loaded address");
  a_deselect: assert property (!i_ctrl_addr_strobe_n &&
    i_cpu_addr_strobe_n && (!i_secondary_select_hi ||
    i_secondary_select_lo_n) |=> !o_selected) else $error("not deselected");
  a_burst_step: assert property (s_step |=>
    o_cur_address[18:2] == $past(o_cur_address[18:2]) &&
    o_cur_address[1:0] != $past(o_cur_address[1:0]))
    else $error("burst address did not step");
  a_oe_gate: assert property (i_output_enable_n |-> &o_data_oe_n)
    else $error("pins driven without output enable");
  a_sleep_quiet: assert property (o_sleeping |->
    &o_data_oe_n && o_lane_we == 2'h0) else $error("activity while asleep");
endmodule
`default_nettype wire

// File: sram_array_model.sv
// Behavioural memory array fed by the block's write queue.
`timescale 1ns/10ps
`default_nettype none
module sram_array_model (
  input  wire logic        i_clk,
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  output logic             o_ready,
  input  wire logic [18:0] i_addr,
  input  wire logic [1:0]  i_lanes,
  input  wire logic [17:0] i_data,
  input  wire logic [18:0] i_raddr,
  output logic      [17:0] o_rdata,
  output logic      [7:0]  o_count
);
  logic [17:0] mem [64] = '{default: 18'h0};
  initial o_count = 8'h0;
  assign o_ready = !i_stall;
  assign o_rdata = mem[i_raddr[5:0]];
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      if (i_lanes[0]) mem[i_addr[5:0]][8:0] <= i_data[8:0];
      if (i_lanes[1]) mem[i_addr[5:0]][17:9] <= i_data[17:9];
      o_count <= o_count + 8'h1;
    end
  end
endmodule
`default_nettype wire

// File: sync_burst_sram_control_tb_top.sv
// Self-checking bench of the burst static memory control block.
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_control_tb_top;
  import sram_pkg::*;
  logic clk = 0, rst_n = 0, ms_n = 0, s_hi = 1, s_lo_n = 0, cpu_n = 1;
  logic ctl_n = 1, step_n = 1, gw_n = 1, bg_n = 1, oe_n = 1, count_order_sel = 1;
  logic sl = 0, stall = 0, slp, sel, wv, wr_rdy, ft_n = 1;
  logic [1:0] ln = 2'h3, we, wl;
  logic [18:0] a = 19'h0, cur, wa, ra;
  logic [17:0] d = 18'h0, q, q_oe, wd, rd;
  logic [7:0] cnt, n0;
  logic [5:0] rows [5] = '{6'h1f, 6'h29, 6'h26, 6'h30, 6'h2c};
  logic [17:0] exp_rd [3] = '{18'h2a5a5, 18'h001a4, 18'h2a400};
  int miscompares = 0, n_tests = 0;
  sync_burst_sram_control i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_word_address(a), .i_master_select_n(ms_n),
    .i_secondary_select_hi(s_hi), .i_secondary_select_lo_n(s_lo_n),
    .i_cpu_addr_strobe_n(cpu_n), .i_ctrl_addr_strobe_n(ctl_n),
    .i_burst_step_n(step_n), .i_global_write_n(gw_n),
    .i_byte_write_gate_n(bg_n), .i_lane_write_n(ln),
    .i_output_enable_n(oe_n), .i_count_order_sel(count_order_sel),
    .i_bypass_pipe_n(ft_n), .i_sleep_req(sl), .i_data(d),
    .o_data(q), .o_data_oe_n(q_oe), .o_sleeping(slp), .o_selected(sel),
    .o_cur_address(cur), .o_lane_we(we), .o_wr_valid(wv),
    .i_wr_ready(wr_rdy), .o_wr_address(wa), .o_wr_lanes(wl),
    .o_wr_data(wd), .o_rd_address(ra), .i_rd_data(rd));
  sram_array_model i_mem (.i_clk(clk), .i_stall(stall), .i_valid(wv),
    .o_ready(wr_rdy), .i_addr(wa), .i_lanes(wl), .i_data(wd),
    .i_raddr(ra), .o_rdata(rd), .o_count(cnt));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string n, input logic [18:0] e, g);
    n_tests++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Inputs move 1 ns after each rising edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_word(input logic [18:0] adr, input logic [17:0] e);
    a = adr; cpu_n = 0; oe_n = 0; tick(1); cpu_n = 1;
    tick(1);
    chk("data", 19'(e), 19'(q));
    chk("oe_n", 19'h0, 19'(q_oe));
    oe_n = 1;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #5000;
    miscompares++;
    test_done();
  end
  initial begin
    tick(12); rst_n = 1; tick(1);
    for (int i = 0; i < 5; i++) begin
      {gw_n, bg_n, ln} = rows[i][5:2];
      a = 19'(i); d = 18'h2a5a5 ^ 18'(i); ctl_n = 0;
      tick(1); ctl_n = 1; gw_n = 1; bg_n = 1; ln = 2'h3;
      chk("lane_we", 19'(rows[i][1:0]), 19'(we));
      tick(1);
    end
    tick(4);
    for (int i = 0; i < 3; i++) rd_word(19'(i), exp_rd[i]);
    ms_n = 1; cpu_n = 0; a = 19'h7; tick(1); ms_n = 0; cpu_n = 1;
    chk("blocked", 19'h2, cur);
    s_hi = 0; ctl_n = 0; tick(1); ctl_n = 1; s_hi = 1;
    chk("deselect", 19'h0, 19'(sel));
    for (int k = 0; k < 2; k++) begin
      count_order_sel = k[0]; a = 19'h5; cpu_n = 0; step_n = 0; tick(1); cpu_n = 1;
      chk("start", 19'h5, cur);
      tick(1); step_n = 1;
      chk("next", k ? 19'h4 : 19'h6, cur);
    end
    n0 = cnt; stall = 1; gw_n = 0; ctl_n = 0; tick(20);
    ctl_n = 1; gw_n = 1; tick(2);
    chk("wr_valid", 19'h1, 19'(wv));
    stall = 0; tick(24);
    chk("taken", 19'h10, 19'(cnt - n0));
    chk("drained", 19'h0, 19'(wv));
    ft_n = 0; a = 19'h2; cpu_n = 0; oe_n = 0; tick(1); cpu_n = 1;
    chk("flow_data", 19'(exp_rd[2]), 19'(q));
    chk("flow_oe_n", 19'h0, 19'(q_oe));
    oe_n = 1; ft_n = 1; tick(2);
    sl = 1; tick(6);
    chk("sleep", 19'h1, 19'(slp));
    sl = 0; tick(6);
    chk("wake", 19'h0, 19'(slp));
    test_done();
  end
endmodule
bind sync_burst_sram_control sram_ctl_assertions u_chk (.*);
`default_nettype wire
